// ===== rtl/fsp_pkg.sv
// Package of constants and carriers for the flash self-programming controller.
package fsp_pkg;

   // ****************************************
   // Register map
   // ****************************************
   localparam logic [7:0] ctrl_offs = 8'h00;
   localparam logic [7:0] cmd_offs = 8'h04;
   localparam logic [7:0] addr_offs = 8'h08;
   localparam logic [7:0] data_offs = 8'h0C;
   localparam logic [7:0] status_offs = 8'h10;
   localparam logic [7:0] secur_offs = 8'h14;
   localparam logic [7:0] irq_stat_offs = 8'h18;
   localparam logic [7:0] irq_clr_offs = 8'h1C;
   localparam logic [7:0] irq_en_offs = 8'h20;
   localparam logic [7:0] bank_offs = 8'h24;
   localparam logic [7:0] real_offs = 8'h28;
   localparam logic [7:0] irq_mask_offs = 8'h2C;

   // ****************************************
   // Field positions and values
   // ****************************************
   localparam int ctrl_enter_bit = 0;
   localparam int ctrl_ext_bit = 1;
   localparam int ctrl_big_bit = 2;
   localparam int sec_chip_bit = 0;
   localparam int sec_blk_bit = 1;
   localparam int sec_wr_bit = 2;
   localparam int sec_boot_bit = 3;
   localparam int ev_done_bit = 0;
   localparam int ev_err_bit = 1;
   localparam int ev_stop_bit = 2;
   localparam logic [31:0] reset_word = 32'h0000_0000;
   localparam logic [3:0] sec_reset = 4'h0;
   localparam logic [31:0] mask_reset = 32'hFFFF_FFFF;
   localparam logic [16:0] common_top = 17'h07FFF;
   localparam logic [16:0] bank_base = 17'h08000;
   localparam logic [16:0] boot_top = 17'h00FFF;
   localparam logic [15:0] window_lo = 16'h8000;
   localparam logic [2:0] banks_small = 3'h4;
   localparam logic [2:0] banks_big = 3'h6;

   // ****************************************
   // Timing
   // ****************************************
   localparam int clk_mhz = 25;
   localparam int osc_wait_us = 10;
   localparam int osc_wait_cyc = osc_wait_us * clk_mhz;
   localparam int op_cyc = 8;

   // ****************************************
   // Types
   // ****************************************
   typedef enum logic [3:0] {
      cmd_none = 4'h0,
      cmd_blank = 4'h1,
      cmd_erase = 4'h2,
      cmd_write = 4'h3,
      cmd_verify = 4'h4,
      cmd_chip_erase = 4'h5,
      cmd_sec_set = 4'h6
   } cmd_t;

   typedef enum logic [2:0] {
      st_idle = 3'b000,
      st_osc = 3'b001,
      st_ready = 3'b010,
      st_busy = 3'b011,
      st_stopped = 3'b100
   } fsm_t;

   typedef struct packed {
      logic cyc;
      logic stb;
      logic we;
      logic [7:0] adr;
      logic [3:0] sel;
      logic [31:0] dat;
   } wb_req_t;

   typedef struct packed {
      logic ack;
      logic [31:0] dat;
   } wb_rsp_t;

endpackage : fsp_pkg

// ===== rtl/flash_self_programming_control.sv
// Flash self-programming controller with security, suspend and bank address mapping.
// Functional notes
// [R1] Chip-erase and boot-zero prohibitions, once set, never clear.
// [R2] Block-erase and write prohibitions clear only by external chip erase.
// [R3] No self-programming while CPU runs on the subsystem clock; here the subsystem clock only blocks entry and resume.
// [R4] Host holds the flash mode select pin high throughout.
// [R5] Pending interrupt request flags stop the running operation.
// [R6] Unmasked requests stop it even when interrupts are globally disabled.
// [R7] Host disables interrupts first; services them in normal mode.
// [R8] Re-entering self-programming mode after a stop allows resuming.
// [R9] Runs on internal oscillator; crystal clock waits stabilization inside.
// [R10] Host keeps the entry routine in the common area.
// [R11] Host gives real flash addresses on large parts; here the host writes CPU addresses and the controller maps them.
// [R12] Common area maps one-to-one onto the lowest real flash.
// [R13] Bank n maps to 08000H plus n times 4000H; high banks prohibited.
// [R14] Host follows begin, setup, blank, erase, write, verify, finish order.
// [R15] Boot cluster zero protection rejects erase and write in all modes.
// [R16] Block-erase and write prohibitions restrict only external programming.
`timescale 1ns/10ps
module flash_self_programming_control (
   input wire logic clk,
   input wire logic rst,
   input wire fsp_pkg::wb_req_t wb_req,
   output fsp_pkg::wb_rsp_t wb_rsp,
   input wire logic flash_mode_select_pin,
   input wire logic cpu_on_subsystem_clk,
   input wire logic cpu_on_crystal_clk,
   input wire logic [31:0] irq_flags,
   output logic irq,
   output logic self_prog_active,
   output logic flash_busy
);
   import fsp_pkg::*;

   // ****************************************
   // State
   // ****************************************
   typedef struct packed {
      fsm_t fsm;
      logic [1:0] pin_sync;
      logic [1:0] sub_sync;
      logic [1:0] xtal_sync;
      logic [63:0] irq_sync;
      logic [2:0] ctrl;
      logic [3:0] cmd;
      logic [16:0] addr;
      logic [31:0] data;
      logic [3:0] sec;
      logic [2:0] ev;
      logic [2:0] ev_en;
      logic [31:0] mask;
      logic [2:0] bank;
      logic [15:0] cnt;
      logic err;
      logic ack;
      logic [31:0] rdat;
      logic irq;
      logic act;
      logic busy;
   } state_t;

   state_t st_reg;
   state_t st_next;

   function automatic logic [16:0] map_addr(input logic [15:0] cpu, input logic [2:0] bank);
      // Bank window keeps the low 14 bits; the bank selects the 16 KB slice.
      if (cpu < window_lo) begin
         map_addr = {1'b0, cpu};
      end else begin
         map_addr = bank_base + {bank, 14'h0000} + {3'h0, cpu[13:0]};
      end
   endfunction : map_addr

   function automatic logic bank_ok(input logic [2:0] bank, input logic big);
      bank_ok = big ? (bank < banks_big) : (bank < banks_small);
   endfunction : bank_ok

   logic [15:0] req_cpu;
   logic [16:0] mapped;
   logic pending;
   logic boot_hit;
   logic hit;
   logic [31:0] w;

   always_comb begin
      st_next = st_reg;
      req_cpu = wb_req.dat[15:0];
      mapped = map_addr(req_cpu, st_reg.bank);
      w = wb_req.dat;
      hit = wb_req.cyc && wb_req.stb && !st_reg.ack;
      // [R5] [R6] Unmasked flags stop.
      pending = |(st_reg.irq_sync[63:32] & ~st_reg.mask);
      boot_hit = st_reg.addr <= boot_top;
      st_next.pin_sync = {st_reg.pin_sync[0], flash_mode_select_pin};
      st_next.sub_sync = {st_reg.sub_sync[0], cpu_on_subsystem_clk};
      st_next.xtal_sync = {st_reg.xtal_sync[0], cpu_on_crystal_clk};
      st_next.irq_sync = {st_reg.irq_sync[31:0], irq_flags};
      st_next.ack = hit;
      if (st_reg.cnt != 16'h0000) begin
         st_next.cnt = st_reg.cnt - 16'h0001;
      end
      case (st_reg.fsm)
         st_idle: begin
            // [R3] Subsystem clock blocks entry.
            if (st_reg.ctrl[ctrl_enter_bit] && st_reg.pin_sync[1] && !st_reg.sub_sync[1]) begin
               st_next.fsm = st_osc;
               // [R9] Oscillator stabilization wait.
               st_next.cnt = st_reg.xtal_sync[1] ? 16'(osc_wait_cyc) : 16'h0001;
            end
         end
         st_osc: begin
            if (st_reg.cnt <= 16'h0001) begin
               st_next.fsm = st_ready;
            end
         end
         st_ready: begin
            if (st_reg.cmd != 4'(cmd_none)) begin
               st_next.fsm = st_busy;
               st_next.cnt = 16'(op_cyc);
               st_next.err = 1'b0;
            end
         end
         st_busy: begin
            if (pending) begin
               st_next.fsm = st_stopped;
               st_next.ev[ev_stop_bit] = 1'b1;
               st_next.ctrl[ctrl_enter_bit] = 1'b0;
            end else if (st_reg.cnt == 16'h0000) begin
               st_next.fsm = st_ready;
               st_next.cmd = 4'(cmd_none);
               // [R15] [R16] Self mode ignores block and write locks.
               if ((st_reg.cmd == 4'(cmd_erase) || st_reg.cmd == 4'(cmd_write))
                   && st_reg.sec[sec_boot_bit] && boot_hit) begin
                  st_next.err = 1'b1;
                  st_next.ev[ev_err_bit] = 1'b1;
               end else if (st_reg.cmd == 4'(cmd_chip_erase)) begin
                  // [R2] Self mode cannot clear locks.
                  st_next.err = 1'b1;
                  st_next.ev[ev_err_bit] = 1'b1;
               end else if (st_reg.cmd == 4'(cmd_sec_set)) begin
                  // [R1] Sticky prohibitions.
                  st_next.sec = st_reg.sec | st_reg.data[3:0];
                  st_next.ev[ev_done_bit] = 1'b1;
               end else begin
                  st_next.ev[ev_done_bit] = 1'b1;
               end
            end
         end
         st_stopped: begin
            // [R8] Resume after re-entry.
            if (st_reg.ctrl[ctrl_enter_bit] && st_reg.pin_sync[1] && !st_reg.sub_sync[1]) begin
               st_next.fsm = st_busy;
               st_next.cnt = 16'(op_cyc);
            end
         end
         default: begin
            st_next.fsm = st_idle;
         end
      endcase
      if (!st_reg.pin_sync[1] || !st_reg.ctrl[ctrl_enter_bit]) begin
         if (st_reg.fsm != st_stopped) begin
            st_next.fsm = st_idle;
         end
      end
      // External chip erase clears block and write locks when allowed.
      if (st_reg.ctrl[ctrl_ext_bit] && st_reg.fsm == st_idle
          && st_reg.cmd == 4'(cmd_chip_erase)) begin
         st_next.cmd = 4'(cmd_none);
         if (!st_reg.sec[sec_chip_bit] && !st_reg.sec[sec_boot_bit]) begin
            // [R2] External chip erase clears.
            st_next.sec[sec_blk_bit] = 1'b0;
            st_next.sec[sec_wr_bit] = 1'b0;
         end
      end
      if (hit && wb_req.we) begin
         case (wb_req.adr)
            ctrl_offs: st_next.ctrl = w[2:0];
            cmd_offs: st_next.cmd = w[3:0];
            addr_offs: begin
               // [R12] [R13] Window translation.
               if (req_cpu >= window_lo && !bank_ok(st_reg.bank, st_reg.ctrl[ctrl_big_bit])) begin
                  st_next.err = 1'b1;
               end else begin
                  st_next.addr = mapped;
               end
            end
            data_offs: st_next.data = w;
            irq_en_offs: st_next.ev_en = w[2:0];
            irq_mask_offs: st_next.mask = w;
            bank_offs: st_next.bank = w[2:0];
            default: begin
            end
         endcase
      end
      if (hit && !wb_req.we) begin
         case (wb_req.adr)
            ctrl_offs: st_next.rdat = {29'h0, st_reg.ctrl};
            cmd_offs: st_next.rdat = {28'h0, st_reg.cmd};
            addr_offs: st_next.rdat = {15'h0, st_reg.addr};
            data_offs: st_next.rdat = st_reg.data;
            status_offs: st_next.rdat = {28'h0, st_reg.err, st_reg.fsm};
            secur_offs: st_next.rdat = {28'h0, st_reg.sec};
            irq_stat_offs: st_next.rdat = {29'h0, st_reg.ev};
            irq_en_offs: st_next.rdat = {29'h0, st_reg.ev_en};
            bank_offs: st_next.rdat = {29'h0, st_reg.bank};
            real_offs: st_next.rdat = {15'h0, mapped};
            irq_mask_offs: st_next.rdat = st_reg.mask;
            default: st_next.rdat = reset_word;
         endcase
      end
      // Clear spares only bits that a same-cycle event newly sets; a bit that was already set is cleared.
      if (hit && wb_req.we && wb_req.adr == irq_clr_offs) begin
         st_next.ev = st_next.ev & ~(w[2:0] & ~(st_next.ev ^ st_reg.ev));
      end
      st_next.irq = |(st_next.ev & st_next.ev_en);
      st_next.act = (st_next.fsm != st_idle);
      st_next.busy = (st_next.fsm == st_busy);
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         st_reg <= '0;
         st_reg.mask <= mask_reset;
         st_reg.sec <= sec_reset;
      end else begin
         st_reg <= st_next;
      end
   end

   assign wb_rsp.ack = st_reg.ack;
   assign wb_rsp.dat = st_reg.rdat;
   assign irq = st_reg.irq;
   assign self_prog_active = st_reg.act;
   assign flash_busy = st_reg.busy;

   // ****************************************
   // Checks
   // ****************************************
   sequence entry_ok_seq;
      st_reg.ctrl[ctrl_enter_bit] && st_reg.pin_sync[1] && !st_reg.sub_sync[1];
   endsequence
   sequence stop_req_seq;
      st_reg.fsm == st_busy && pending;
   endsequence
   sequence op_end_seq;
      st_reg.fsm == st_busy && st_reg.cnt == 16'h0000 && !pending;
   endsequence

   // [R1] Chip lock sticky.
   chk_chip_lock_sticky: assert property (@(posedge clk) disable iff (rst) // [R1]
      st_reg.sec[sec_chip_bit] |=> st_reg.sec[sec_chip_bit])
      else $error("Chip erase lock cleared.");

   // [R1] Boot lock sticky.
   chk_boot_lock_sticky: assert property (@(posedge clk) disable iff (rst) // [R1]
      st_reg.sec[sec_boot_bit] |=> st_reg.sec[sec_boot_bit])
      else $error("Boot cluster lock cleared.");

   // [R2] No self clear.
   chk_self_no_clear: assert property (@(posedge clk) disable iff (rst) // [R2]
      (st_reg.fsm != st_idle && st_reg.sec[sec_blk_bit]) |=> st_reg.sec[sec_blk_bit])
      else $error("Block lock cleared in self mode.");

   // [R2] Self chip erase refused.
   chk_self_chip_refused: assert property (@(posedge clk) disable iff (rst) // [R2]
      (op_end_seq ##0 (st_reg.cmd == 4'(cmd_chip_erase)))
      |=> (st_reg.err && st_reg.sec == $past(st_reg.sec)))
      else $error("Chip erase accepted in self mode.");

   // [R2] External clear only.
   chk_ext_clear_only: assert property (@(posedge clk) disable iff (rst) // [R2]
      $fell(st_reg.sec[sec_blk_bit]) |-> ($past(st_reg.fsm) == st_idle
      && $past(st_reg.ctrl[ctrl_ext_bit]) && !$past(st_reg.sec[sec_chip_bit])))
      else $error("Block lock cleared outside external chip erase.");

   // [R3] Subsystem clock blocks.
   chk_sub_blocks: assert property (@(posedge clk) disable iff (rst) // [R3]
      (st_reg.fsm == st_idle && st_reg.sub_sync[1]) |=> st_reg.fsm == st_idle)
      else $error("Entered on subsystem clock.");

   // [R5] Stop on request.
   chk_stop_on_irq: assert property (@(posedge clk) disable iff (rst) // [R5] [R6]
      stop_req_seq |=> st_reg.fsm == st_stopped)
      else $error("Pending request did not stop.");

   // [R5] Stop marks event.
   chk_stop_marks: assert property (@(posedge clk) disable iff (rst) // [R5]
      (stop_req_seq ##0 !hit) |=> (st_reg.ev[ev_stop_bit] && !st_reg.ctrl[ctrl_enter_bit]))
      else $error("Stop left no event or kept entry.");

   // [R6] Masked flags ignored.
   chk_masked_ignored: assert property (@(posedge clk) disable iff (rst) // [R6]
      (entry_ok_seq ##0 (st_reg.fsm == st_busy && !pending && st_reg.cnt != 16'h0000))
      |=> st_reg.fsm == st_busy)
      else $error("Masked request stopped the operation.");

   // [R8] Resume path.
   chk_resume_path: assert property (@(posedge clk) disable iff (rst) // [R8]
      (entry_ok_seq ##0 (st_reg.fsm == st_stopped))
      |=> (st_reg.fsm == st_busy && st_reg.cnt == 16'(op_cyc)))
      else $error("Stopped operation did not resume.");

   // [R9] Crystal wait loaded.
   chk_osc_load: assert property (@(posedge clk) disable iff (rst) // [R9]
      (entry_ok_seq ##0 (st_reg.fsm == st_idle && st_reg.xtal_sync[1]))
      |=> (st_reg.fsm == st_osc && st_reg.cnt == 16'(osc_wait_cyc)))
      else $error("Oscillator wait not loaded.");

   // [R9] Internal oscillator entry.
   chk_osc_short: assert property (@(posedge clk) disable iff (rst) // [R9]
      (entry_ok_seq ##0 (st_reg.fsm == st_idle && !st_reg.xtal_sync[1]))
      |=> (st_reg.fsm == st_osc && st_reg.cnt == 16'h0001))
      else $error("Internal oscillator entry delayed.");

   // [R9] Crystal wait.
   chk_osc_wait: assert property (@(posedge clk) disable iff (rst) // [R9]
      (st_reg.fsm == st_osc && st_reg.cnt > 16'h0001) |=> st_reg.fsm != st_ready)
      else $error("Oscillator wait cut short.");

   // [R9] Wait then ready.
   chk_osc_done: assert property (@(posedge clk) disable iff (rst) // [R9]
      (entry_ok_seq ##0 (st_reg.fsm == st_osc && st_reg.cnt <= 16'h0001))
      |=> st_reg.fsm == st_ready)
      else $error("Ready not reached after the wait.");

   // [R12] Common area direct.
   chk_common_map: assert property (@(posedge clk) disable iff (rst) // [R12]
      (hit && wb_req.we && wb_req.adr == addr_offs && req_cpu < window_lo)
      |=> st_reg.addr == {1'b0, $past(req_cpu)})
      else $error("Common area address translated.");

   // [R13] Bank mapping.
   chk_bank_map: assert property (@(posedge clk) disable iff (rst) // [R12] [R13]
      (hit && wb_req.we && wb_req.adr == addr_offs && req_cpu >= window_lo
       && bank_ok(st_reg.bank, st_reg.ctrl[ctrl_big_bit])) |=> st_reg.addr == $past(mapped))
      else $error("Bank address wrong.");

   // [R13] Prohibited bank refused.
   chk_bank_refused: assert property (@(posedge clk) disable iff (rst) // [R13]
      (hit && wb_req.we && wb_req.adr == addr_offs && req_cpu >= window_lo
       && !bank_ok(st_reg.bank, st_reg.ctrl[ctrl_big_bit]))
      |=> (st_reg.err && $stable(st_reg.addr)))
      else $error("Prohibited bank accepted.");

   // [R15] Boot protect.
   chk_boot_protect: assert property (@(posedge clk) disable iff (rst) // [R15]
      (st_reg.fsm == st_busy && st_reg.cnt == 16'h0000 && !pending && boot_hit
       && st_reg.sec[sec_boot_bit] && st_reg.cmd == 4'(cmd_erase)) |=> st_reg.err)
      else $error("Boot cluster erased.");

   // [R15] Boot write refused.
   chk_boot_write: assert property (@(posedge clk) disable iff (rst) // [R15]
      (op_end_seq ##0 (boot_hit && st_reg.sec[sec_boot_bit] && st_reg.cmd == 4'(cmd_write)))
      |=> st_reg.err)
      else $error("Boot cluster written.");

   // [R16] Locks spare self mode.
   chk_self_lock_free: assert property (@(posedge clk) disable iff (rst) // [R16]
      (op_end_seq ##0 (!hit && !st_reg.err && !(boot_hit && st_reg.sec[sec_boot_bit])
       && (st_reg.cmd == 4'(cmd_erase) || st_reg.cmd == 4'(cmd_write))))
      |=> (!st_reg.err && st_reg.ev[ev_done_bit]))
      else $error("Self mode operation refused by a lock.");

endmodule : flash_self_programming_control

// ===== tb/cpu_host_model.sv
// CPU side model: bus master and pin driver of the rewrite program.
`timescale 1ns/10ps
module cpu_host_model (
   input wire logic clk,
   input wire fsp_pkg::wb_rsp_t wb_rsp,
   output fsp_pkg::wb_req_t wb_req,
   output logic flash_mode_select_pin,
   output logic [31:0] irq_flags
);
   import fsp_pkg::*;
   // ****************************************
   // Bus master and pins
   // ****************************************
   initial begin
      wb_req = '0;
      flash_mode_select_pin = 1'b0;
      irq_flags = '0;
   end
   // Ordered host steps.
   // Released lines show the inverse so stale values cannot pass for live ones.
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q);
      wb_req <= '{cyc: 1'b1, stb: 1'b1, we: w, adr: a, sel: 4'hF, dat: d};
      @(posedge clk);
      while (wb_rsp.ack !== 1'b1) begin
         @(posedge clk);
      end
      q = wb_rsp.dat;
      wb_req <= '{cyc: 1'b0, stb: 1'b0, we: ~w, adr: ~a, sel: 4'h0, dat: ~d};
      @(posedge clk);
   endtask : bus
   task automatic pin(input logic v);
      flash_mode_select_pin <= v;
   endtask : pin
   task automatic raise(input logic [31:0] f);
      irq_flags <= f;
   endtask : raise
endmodule : cpu_host_model

// ===== tb/tb_flash_self_programming_control.sv
// Self-checking bench of the flash self-programming controller.
`timescale 1ns/10ps
`define CHK(nm, e, s) begin n_checks++; if ((s) !== (e)) begin err_total++; \
   $display("BAD %s expected %0h seen %0h", nm, e, s); end end
module tb_flash_self_programming_control;
   import fsp_pkg::*;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic sub_clk = 1'b0;
   logic xtal = 1'b0;
   wb_req_t wb_req;
   wb_rsp_t wb_rsp;
   logic pin;
   logic [31:0] flags;
   logic irq, act, busy, big, bad;
   logic [31:0] q, prev;
   logic [2:0] bk;
   logic [15:0] ca;
   logic [17:0] m;
   int err_total = 0;
   int n_checks = 0;
   always #20 clk = ~clk;
   flash_self_programming_control dut_u (.clk(clk), .rst(rst), .wb_req(wb_req),
      .wb_rsp(wb_rsp), .flash_mode_select_pin(pin), .cpu_on_subsystem_clk(sub_clk),
      .cpu_on_crystal_clk(xtal), .irq_flags(flags), .irq(irq), .self_prog_active(act),
      .flash_busy(busy));
   cpu_host_model host_u (.clk(clk), .wb_rsp(wb_rsp), .wb_req(wb_req),
      .flash_mode_select_pin(pin), .irq_flags(flags));
   // ****************************************
   // Helpers
   // ****************************************
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      host_u.bus(1'b1, a, d, q);
   endtask : wr
   task automatic rd(input logic [7:0] a);
      host_u.bus(1'b0, a, 32'h0, q);
   endtask : rd
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
   endtask : cyc
   // Valid flag above the real address; the 16 KB window keeps the low 14 address bits.
   function automatic logic [17:0] map(input logic g, input logic [2:0] b, input logic [15:0] c);
      if (c <= common_top[15:0]) return {1'b1, 1'b0, c};
      return {b < (g ? banks_big : banks_small),
              bank_base + 17'(b) * 17'h04000 + 17'(c[13:0])};
   endfunction : map
   task automatic complete_run();
      $display("checks %0d mismatches %0d", n_checks, err_total);
      if (err_total == 0 && n_checks > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask : complete_run
   initial begin
      #400000;
      err_total++;
      complete_run();
   end
   // ****************************************
   // Tests
   // ****************************************
   initial begin
      void'($urandom(22));
      cyc(20);
      rst <= 1'b0;
      cyc(2);
      rd(secur_offs);
      `CHK("secur reset", 32'(sec_reset), q)
      rd(irq_mask_offs);
      `CHK("mask reset", mask_reset, q)
      rd(8'h30);
      `CHK("unmapped", 32'h0, q)
      $display("test reset done");
      prev = reset_word;
      bad = 1'b0;
      for (int i = 0; i < 16; i++) begin
         big = 1'($urandom);
         bk = 3'($urandom);
         ca = 16'($urandom);
         case (i)
            0: ca = 16'h7FFF;
            1: {big, bk, ca} = {1'b1, 3'h5, 16'hFFFF};
            2: {big, bk, ca} = {1'b0, 3'h4, 16'h8000};
            default: ;
         endcase
         m = map(big, bk, ca);
         wr(ctrl_offs, 32'(big) << ctrl_big_bit);
         wr(bank_offs, 32'(bk));
         wr(addr_offs, 32'(ca));
         if (m[17]) prev = 32'(m[16:0]);
         // The status error flag stays set until the next command starts.
         bad = bad | ~m[17];
         rd(addr_offs);
         `CHK("real addr", prev, q)
         rd(status_offs);
         `CHK("bank err", bad, q[3])
         wr(irq_clr_offs, 32'h7);
      end
      $display("test mapping done");
      host_u.pin(1'b1);
      sub_clk <= 1'b1;
      cyc(4);
      wr(ctrl_offs, 32'h1);
      cyc(6);
      `CHK("subclock entry", 1'b0, act)
      sub_clk <= 1'b0;
      xtal <= 1'b1;
      cyc(4);
      wr(ctrl_offs, 32'h1);
      cyc(200);
      rd(status_offs);
      `CHK("osc wait", st_osc, q[2:0])
      cyc(60);
      rd(status_offs);
      `CHK("osc over", st_ready, q[2:0])
      $display("test entry done");
      wr(irq_en_offs, 32'h1 << ev_stop_bit);
      wr(irq_mask_offs, 32'hFFFF_FFFE);
      host_u.raise(32'h8000_0000);
      wr(cmd_offs, 32'(cmd_write));
      cyc(3);
      `CHK("masked flag", 1'b1, busy)
      cyc(op_cyc);
      rd(irq_stat_offs);
      `CHK("done event", 32'h1, q)
      wr(irq_clr_offs, 32'h7);
      wr(cmd_offs, 32'(cmd_erase));
      host_u.raise(32'h8000_0001);
      cyc(op_cyc + 4);
      rd(status_offs);
      `CHK("stopped", st_stopped, q[2:0])
      rd(irq_stat_offs);
      `CHK("stop event", 32'h4, q)
      `CHK("irq on", 1'b1, irq)
      wr(irq_en_offs, 32'h0);
      `CHK("irq off", 1'b0, irq)
      host_u.raise(32'h0);
      xtal <= 1'b0;
      wr(irq_clr_offs, 32'h7);
      wr(ctrl_offs, 32'h1);
      cyc(6);
      wr(cmd_offs, 32'(cmd_erase));
      cyc(op_cyc + 4);
      rd(irq_stat_offs);
      `CHK("resume", 32'h1, q)
      $display("test stop done");
      wr(data_offs, 32'h6);
      wr(cmd_offs, 32'(cmd_sec_set));
      cyc(op_cyc + 4);
      wr(cmd_offs, 32'(cmd_chip_erase));
      cyc(op_cyc + 4);
      rd(secur_offs);
      `CHK("self chip erase", 32'h6, q)
      wr(addr_offs, 32'h2000);
      wr(irq_clr_offs, 32'h7);
      wr(cmd_offs, 32'(cmd_erase));
      cyc(op_cyc + 4);
      rd(irq_stat_offs);
      `CHK("self erase", 32'h1, q)
      wr(ctrl_offs, 32'h1 << ctrl_ext_bit);
      cyc(4);
      wr(cmd_offs, 32'(cmd_chip_erase));
      cyc(op_cyc + 4);
      rd(secur_offs);
      `CHK("ext chip erase", 32'h0, q)
      wr(ctrl_offs, 32'h1);
      cyc(6);
      wr(data_offs, 32'h9);
      wr(cmd_offs, 32'(cmd_sec_set));
      cyc(op_cyc + 4);
      wr(addr_offs, 32'h0800);
      wr(irq_clr_offs, 32'h7);
      wr(cmd_offs, 32'(cmd_write));
      cyc(op_cyc + 4);
      rd(irq_stat_offs);
      `CHK("boot write", 2'b10, q[1:0])
      wr(ctrl_offs, 32'h1 << ctrl_ext_bit);
      cyc(4);
      wr(cmd_offs, 32'(cmd_chip_erase));
      cyc(op_cyc + 4);
      rd(secur_offs);
      `CHK("locks kept", 32'h9, q)
      host_u.pin(1'b0);
      $display("test security done");
      complete_run();
   end
endmodule : tb_flash_self_programming_control
